// >>> design/smc_core.sv
`include "smc_map.svh"
module smc_core import smc_pkg::*; #(
   parameter int CLK_HZ = `SMC_CLK_HZ,
   parameter int SIMUL_MS = `SMC_SIMUL_MS,
   parameter int OVR_MAX_MS = `SMC_OVR_MAX_MS,
   parameter int OVR_REARM_MS = `SMC_OVR_REARM_MS,
   parameter int RST_MIN_MS = `SMC_RST_MIN_MS,
   parameter int RST_MAX_MS = `SMC_RST_MAX_MS,
   parameter int PULSE_US = `SMC_PULSE_US,
   parameter int PULSE_PERIOD_MS = `SMC_PULSE_PERIOD_MS,
   parameter int MS_CYCLES = CLK_HZ / 1000,
   parameter bit SOLID_STATE = 1'b1
) (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic clk_en_in,
   input wire logic mutable_stop_chan_a_in,
   input wire logic mutable_stop_chan_b_in,
   input wire logic protective_stop_chan_a_in,
   input wire logic protective_stop_chan_b_in,
   input wire logic [3:0] mute_sensor_in,
   input wire logic mute_enable_input_in,
   input wire logic [1:0] override_in,
   input wire logic reset_input_in,
   input wire logic [1:0] external_feedback_monitor_in,
   input wire logic [`SMC_CFG_W-1:0] cfg_bank_a_in,
   input wire logic [`SMC_CFG_W-1:0] cfg_bank_b_in,
   input wire logic [8:0] lamp_current_ma_in,
   output logic [1:0] safety_output_out,
   output logic aux_output_out,
   output logic mute_lamp_output_out,
   output logic led_red_out,
   output logic led_green_out,
   output logic led_amber_out,
   output logic [13:0] input_led_out,
   output logic [7:0] display_out
);
   // config bits: 0 manual reset, 1 two-way, 2 lamp mon, 4:3 feedback, 6:5 mute time, 7 unused
   localparam int MS_W = 16;
   localparam int SUB_W = 17;
   localparam int PULSE_CYC = (PULSE_US * MS_CYCLES) / 1000 < 1 ? 1 :
      (PULSE_US * MS_CYCLES) / 1000;
   localparam int NIN = 14;

   initial begin
      if (MS_CYCLES < 2 || MS_CYCLES >= (1 << SUB_W)) $error("MS_CYCLES out of range");
      if (PULSE_US >= 100 || PULSE_PERIOD_MS <= 100) $error("test pulse timing invalid");
      if (RST_MIN_MS >= RST_MAX_MS) $error("reset window invalid");
   end

   // ************************************************
   // functions
   // ************************************************
   function automatic logic override_both(input logic [NIN-1:0] d);
      override_both = d[9] && d[10];
   endfunction : override_both

   function automatic logic [MS_W-1:0] mute_limit_ms(input logic [1:0] sel);
      case (sel)
         2'h0: mute_limit_ms = 16'h0000;
         2'h1: mute_limit_ms = 16'h7530;
         2'h2: mute_limit_ms = 16'hEA60;
         default: mute_limit_ms = 16'hFFFF;
      endcase
   endfunction : mute_limit_ms

   function automatic logic [MS_W-1:0] inc_sat(input logic [MS_W-1:0] v);
      inc_sat = (v == 16'hFFFF) ? v : v + 16'h0001;
   endfunction : inc_sat

   // ************************************************
   // state
   // ************************************************
   typedef struct packed {
      logic [NIN-1:0] s1;
      logic [NIN-1:0] s2;
      logic [NIN-1:0] s3;
      logic [NIN-1:0] din;
      smc_state_t st;
      logic [SUB_W-1:0] sub;
      logic [MS_W-1:0] simul_ms;
      logic simul_run;
      logic [MS_W-1:0] mute_ms;
      logic [MS_W-1:0] ovr_ms;
      logic [MS_W-1:0] ovr_open_ms;
      logic [MS_W-1:0] ovr_sim_ms;
      logic ovr_armed;
      logic [MS_W-1:0] rst_ms;
      logic lamp_fail;
      logic err50;
      logic [7:0] err;
      logic [MS_W-1:0] pls_ms;
      logic [SUB_W-1:0] pls_cyc;
      logic [1:0] out;
   } smc_reg_t;

   smc_reg_t state_reg;
   smc_reg_t state_next;

   logic [NIN-1:0] raw;
   logic ms_tick;
   logic ms_open;
   logic ps_open;
   logic any_sensor;
   logic pair1;
   logic pair2;
   logic rst_pulse;
   logic ovr_start;
   logic fb_bad;
   logic cfg_bad;
   logic lamp_bad;
   logic [MS_W-1:0] lim;
   logic mute_start;

   // ************************************************
   // input bit order
   // ************************************************
   // 0..3 stops, 4..7 sensors, 8 enable, 10:9 override, 11 reset, 13:12 feedback
   assign raw = {external_feedback_monitor_in,
      reset_input_in, override_in, mute_enable_input_in, mute_sensor_in,
      protective_stop_chan_b_in, protective_stop_chan_a_in,
      mutable_stop_chan_b_in, mutable_stop_chan_a_in};

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      state_next = state_reg;
      state_next.s1 = raw;
      state_next.s2 = state_reg.s1;
      state_next.s3 = state_reg.s2;
      for (int i = 0; i < NIN; i++) begin
         if (state_reg.s2[i] == state_reg.s3[i]) begin
            state_next.din[i] = state_reg.s3[i];
         end
      end
      ms_tick = state_reg.sub == SUB_W'(MS_CYCLES - 1);
      state_next.sub = ms_tick ? '0 : state_reg.sub + 1'b1;
      ms_open = !(state_reg.din[0] && state_reg.din[1]);
      ps_open = !(state_reg.din[2] && state_reg.din[3]);
      any_sensor = |state_reg.din[7:4];
      pair1 = state_reg.din[4] && state_reg.din[5];
      pair2 = state_reg.din[6] && state_reg.din[7];
      cfg_bad = cfg_bank_a_in != cfg_bank_b_in;
      lim = mute_limit_ms(cfg_bank_a_in[6:5]);
      lamp_bad = cfg_bank_a_in[2] && state_reg.st == SMC_ST_MUTE &&
         (lamp_current_ma_in < 9'(`SMC_LAMP_MIN_MA) ||
          lamp_current_ma_in > 9'(`SMC_LAMP_MAX_MA));
      case (cfg_bank_a_in[4:3])
         `SMC_FB_ONE: fb_bad = state_reg.out == 2'b00 && !state_reg.din[12];
         `SMC_FB_TWO: fb_bad = state_reg.out == 2'b00 && !(&state_reg.din[13:12]);
         default: fb_bad = 1'b0;
      endcase
      // reset pulse on release, hold time checked
      rst_pulse = state_reg.din[11] == 1'b0 && state_reg.rst_ms >= MS_W'(RST_MIN_MS) &&
         state_reg.rst_ms <= MS_W'(RST_MAX_MS);
      if (state_reg.din[11]) begin
         if (ms_tick) state_next.rst_ms = inc_sat(state_reg.rst_ms);
      end else begin
         state_next.rst_ms = '0;
      end
      // simultaneity window from first sensor of either pair
      if (!any_sensor) begin
         state_next.simul_run = 1'b0;
         state_next.simul_ms = '0;
      end else begin
         state_next.simul_run = 1'b1;
         if (ms_tick) state_next.simul_ms = inc_sat(state_reg.simul_ms);
      end
      mute_start = state_reg.din[8] && !state_reg.lamp_fail && !state_reg.err50 &&
         state_reg.simul_ms < MS_W'(SIMUL_MS) &&
         (pair1 || (cfg_bank_a_in[1] && pair2));
      // override arming: both open for rearm time
      if (state_reg.din[10:9] == 2'b00) begin
         if (ms_tick) state_next.ovr_open_ms = inc_sat(state_reg.ovr_open_ms);
         if (state_reg.ovr_open_ms >= MS_W'(OVR_REARM_MS)) state_next.ovr_armed = 1'b1;
      end else begin
         state_next.ovr_open_ms = '0;
      end
      // override simultaneity from first channel closed
      if (state_reg.din[10:9] == 2'b00) begin
         state_next.ovr_sim_ms = '0;
      end else if (ms_tick) begin
         state_next.ovr_sim_ms = inc_sat(state_reg.ovr_sim_ms);
      end
      ovr_start = state_reg.ovr_armed && override_both(state_reg.din) &&
         state_reg.ovr_sim_ms < MS_W'(SIMUL_MS) && any_sensor;
      if (state_reg.lamp_fail == 1'b0 && lamp_bad) state_next.lamp_fail = 1'b1;
      if (state_reg.err50 && !any_sensor && !ms_open) state_next.err50 = 1'b0;
      case (state_reg.st)
         SMC_ST_WAIT_RESET: begin
            if (!ms_open && !ps_open && (!cfg_bank_a_in[0] || rst_pulse)) begin
               state_next.st = SMC_ST_RUN;
            end
         end
         SMC_ST_RUN: begin
            if (ps_open) begin
               state_next.st = SMC_ST_WAIT_RESET;
            end else if (mute_start) begin
               state_next.st = SMC_ST_MUTE;
               state_next.mute_ms = lim;
            end else if (ms_open) begin
               state_next.st = SMC_ST_TRIPPED;
            end
         end
         SMC_ST_MUTE: begin
            if (ps_open) begin
               state_next.st = SMC_ST_WAIT_RESET;
            end else if (lim != 16'h0000 && state_reg.mute_ms == 16'h0000) begin
               state_next.err50 = 1'b1;
               state_next.st = ms_open ? SMC_ST_TRIPPED : SMC_ST_RUN;
            end else if (!any_sensor) begin
               state_next.st = ms_open ? SMC_ST_TRIPPED : SMC_ST_RUN;
            end else if (ms_tick && lim != 16'h0000) begin
               state_next.mute_ms = state_reg.mute_ms - 16'h0001;
            end
         end
         SMC_ST_TRIPPED: begin
            if (ovr_start && !ps_open) begin
               state_next.st = SMC_ST_OVERRIDE;
               state_next.ovr_ms = '0;
               state_next.ovr_armed = 1'b0;
            end else if (!ms_open && (!cfg_bank_a_in[0] || rst_pulse)) begin
               state_next.st = SMC_ST_RUN;
            end
         end
         SMC_ST_OVERRIDE: begin
            if (ms_tick) state_next.ovr_ms = inc_sat(state_reg.ovr_ms);
            if (ps_open || !override_both(state_reg.din) ||
               state_reg.ovr_ms >= MS_W'(OVR_MAX_MS)) begin
               state_next.st = SMC_ST_TRIPPED;
            end
         end
         SMC_ST_LOCKOUT: begin
            if (!cfg_bad && rst_pulse) state_next.st = SMC_ST_WAIT_RESET;
         end
         default: state_next.st = SMC_ST_LOCKOUT;
      endcase
      if (cfg_bad) begin
         state_next.st = SMC_ST_LOCKOUT;
         state_next.err = `SMC_ERR_CFG;
      end else if (fb_bad && state_reg.st != SMC_ST_WAIT_RESET) begin
         state_next.st = SMC_ST_LOCKOUT;
         state_next.err = `SMC_ERR_FEEDBACK;
      end else if (state_reg.st != SMC_ST_LOCKOUT) begin
         state_next.err = state_reg.err50 ? `SMC_ERR_MUTE_TIME :
            (state_reg.lamp_fail ? `SMC_ERR_LAMP : `SMC_ERR_NONE);
      end
      // test pulse timer
      if (ms_tick) state_next.pls_ms = state_reg.pls_ms + 16'h0001;
      if (state_reg.pls_ms >= MS_W'(PULSE_PERIOD_MS)) begin
         state_next.pls_ms = '0;
         state_next.pls_cyc = SUB_W'(PULSE_CYC);
      end else if (state_reg.pls_cyc != '0) begin
         state_next.pls_cyc = state_reg.pls_cyc - 1'b1;
      end
      state_next.out = (state_next.st == SMC_ST_RUN || state_next.st == SMC_ST_MUTE ||
         state_next.st == SMC_ST_OVERRIDE) ? 2'b11 : 2'b00;
   end

   always_ff @(posedge clock_in) begin
      if (rst_in) begin
         state_reg <= '0;
      end else if (clk_en_in) begin
         state_reg <= state_next;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   always_comb begin
      safety_output_out = state_reg.out;
      if (SOLID_STATE && state_reg.pls_cyc != '0) safety_output_out = 2'b00;
      aux_output_out = &state_reg.out;
      mute_lamp_output_out = state_reg.st == SMC_ST_MUTE;
      led_red_out = state_reg.st == SMC_ST_LOCKOUT || state_reg.out == 2'b00;
      led_green_out = state_reg.out == 2'b11;
      led_amber_out = state_reg.st == SMC_ST_WAIT_RESET || state_reg.st == SMC_ST_OVERRIDE;
      input_led_out = state_reg.din;
      display_out = state_reg.err != `SMC_ERR_NONE ? state_reg.err :
         (state_reg.st == SMC_ST_MUTE ? state_reg.mute_ms[15:8] : 8'h00);
   end

   // ************************************************
   // assertions
   // ************************************************
   chk_ps_off: assert property (@(posedge clock_in) disable iff (rst_in)
      clk_en_in && !(state_reg.din[2] && state_reg.din[3]) |=> state_reg.out == 2'b00)
      else $error("outputs on with protective stop open");
   chk_mute_hold: assert property (@(posedge clock_in) disable iff (rst_in)
      state_reg.st == SMC_ST_MUTE |-> state_reg.out == 2'b11)
      else $error("outputs off during mute");
   chk_cfg_lock: assert property (@(posedge clock_in) disable iff (rst_in)
      clk_en_in && cfg_bank_a_in != cfg_bank_b_in |=> state_reg.st == SMC_ST_LOCKOUT)
      else $error("no lockout on bank mismatch");
   chk_aux_follow: assert property (@(posedge clock_in) disable iff (rst_in)
      aux_output_out == (state_reg.out == 2'b11))
      else $error("aux differs from safety outputs");
   chk_err50_show: assert property (@(posedge clock_in) disable iff (rst_in)
      state_reg.err50 && state_reg.st != SMC_ST_LOCKOUT && clk_en_in && !cfg_bad && !fb_bad
      |=> display_out == `SMC_ERR_MUTE_TIME)
      else $error("mute time code missing");
   chk_mute_enable: assert property (@(posedge clock_in) disable iff (rst_in)
      $rose(state_reg.st == SMC_ST_MUTE) |-> $past(state_reg.din[8]))
      else $error("mute started without enable");
   chk_ovr_cause: assert property (@(posedge clock_in) disable iff (rst_in)
      $rose(state_reg.st == SMC_ST_OVERRIDE) |-> $past(state_reg.st) == SMC_ST_TRIPPED)
      else $error("override without trip");
   chk_ovr_end: assert property (@(posedge clock_in) disable iff (rst_in)
      state_reg.st == SMC_ST_OVERRIDE && clk_en_in && !override_both(state_reg.din)
      |=> state_reg.st != SMC_ST_OVERRIDE)
      else $error("override kept with channel open");
   chk_unmute_off: assert property (@(posedge clock_in) disable iff (rst_in)
      state_reg.st == SMC_ST_RUN && clk_en_in && !(state_reg.din[0] && state_reg.din[1])
      |=> state_reg.out != 2'b11 || state_reg.st == SMC_ST_MUTE)
      else $error("outputs on with mutable stop open");
endmodule : smc_core

// >>> design/smc_map.svh
`ifndef SMC_MAP_SVH
`define SMC_MAP_SVH
`define SMC_CLK_HZ 125000000
`define SMC_SIMUL_MS 3000
`define SMC_OVR_MAX_MS 30000
`define SMC_OVR_REARM_MS 3000
`define SMC_RST_MIN_MS 250
`define SMC_RST_MAX_MS 2000
`define SMC_PULSE_US 50
`define SMC_PULSE_PERIOD_MS 150
`define SMC_RESP_SS_MS 10
`define SMC_RESP_RLY_MS 20
`define SMC_LAMP_MIN_MA 10
`define SMC_LAMP_MAX_MA 360
`define SMC_ERR_NONE 8'h00
`define SMC_ERR_CFG 8'h20
`define SMC_ERR_FEEDBACK 8'h30
`define SMC_ERR_LAMP 8'h40
`define SMC_ERR_MUTE_TIME 8'h50
`define SMC_FB_OFF 2'h0
`define SMC_FB_ONE 2'h1
`define SMC_FB_TWO 2'h2
`define SMC_CFG_W 8
`endif

// >>> design/smc_pkg.sv
package smc_pkg;
   typedef enum logic [2:0] {
      SMC_ST_WAIT_RESET = 3'b000,
      SMC_ST_RUN = 3'b001,
      SMC_ST_MUTE = 3'b010,
      SMC_ST_TRIPPED = 3'b011,
      SMC_ST_OVERRIDE = 3'b100,
      SMC_ST_LOCKOUT = 3'b101
   } smc_state_t;
endpackage : smc_pkg

// >>> tb/smc_core_test.sv
`include "smc_map.svh"
module smc_core_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MS = 20;
   localparam int SIMUL = 100;
   localparam int OVR_MAX = 200;
   localparam int REARM = 100;
   localparam int RESP = 10;
   // manual reset, two-way, no lamp check, no feedback, no mute limit
   localparam logic [7:0] CFG = 8'h03;
   logic clock_in = 1'b0;
   logic rst_in = 1'b1;
   logic mut_a = 1'b1;
   logic mut_b = 1'b1;
   logic prot_a = 1'b1;
   logic prot_b = 1'b1;
   logic enable = 1'b0;
   logic [7:0] cfg_b = CFG;
   logic [7:0] cfg_a = CFG;
   logic [8:0] lamp_ma = 9'h064;
   logic clk_en = 1'b1;
   logic [3:0] sensors;
   logic [1:0] ovr;
   logic rst_btn;
   logic [1:0] fb;
   logic [1:0] outs;
   logic aux;
   logic lamp;
   logic [7:0] disp;
   int error_cnt = 0;
   int comparisons = 0;
   always #4 clock_in = ~clock_in;
   smc_core #(.CLK_HZ(MS * 1000), .SIMUL_MS(SIMUL), .OVR_MAX_MS(OVR_MAX), .OVR_REARM_MS(REARM),
      .RST_MIN_MS(25), .RST_MAX_MS(200), .MS_CYCLES(MS)) smc_core_i (
      .clock_in(clock_in), .rst_in(rst_in), .clk_en_in(clk_en),
      .mutable_stop_chan_a_in(mut_a), .mutable_stop_chan_b_in(mut_b),
      .protective_stop_chan_a_in(prot_a), .protective_stop_chan_b_in(prot_b),
      .mute_sensor_in(sensors), .mute_enable_input_in(enable), .override_in(ovr),
      .reset_input_in(rst_btn), .external_feedback_monitor_in(fb), .cfg_bank_a_in(cfg_a),
      .cfg_bank_b_in(cfg_b), .lamp_current_ma_in(lamp_ma), .safety_output_out(outs),
      .aux_output_out(aux), .mute_lamp_output_out(lamp), .led_red_out(), .led_green_out(),
      .led_amber_out(), .input_led_out(), .display_out(disp));
   smc_field_model #(.MS(MS)) smc_field_model_i (.clock_in(clock_in), .safety_output_in(outs),
      .mute_sensor_out(sensors), .override_out(ovr), .reset_input_out(rst_btn),
      .feedback_out(fb));
   // ****************************************
   // checking helpers and scenarios
   // ****************************************
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         error_cnt++;
         $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic probe(input int sel);
      case (sel)
         0: return outs === 2'h3;
         1: return outs === 2'h0 && aux === 1'b0;
         default: return lamp === 1'b1;
      endcase
   endfunction : probe
   task automatic expect_within(input int sel, input int n);
      int i;
      for (i = 0; i < n && !probe(sel); i++) begin
         @(posedge clock_in);
         #1;
      end
      check({7'h00, probe(sel)}, 8'h01);
   endtask : expect_within
   // one-cycle test pulses tolerated
   task automatic hold_on(input int n);
      int run;
      int worst;
      run = 0;
      worst = 0;
      repeat (n) begin
         @(posedge clock_in);
         #1;
         run = probe(0) ? 0 : run + 1;
         if (run > worst) worst = run;
      end
      check({7'h00, worst > 1}, 8'h00);
   endtask : hold_on
   task automatic rearm();
      smc_field_model_i.wait_ms(20);
      smc_field_model_i.reset_pulse(50);
      expect_within(0, 50 * MS);
   endtask : rearm
   task automatic t_trip();
      @(posedge clock_in);
      mut_b <= 1'b0;
      expect_within(1, RESP * MS);
      check({7'h00, aux}, 8'h00);
      @(posedge clock_in);
      mut_b <= 1'b1;
      smc_field_model_i.reset_pulse(250);
      smc_field_model_i.wait_ms(20);
      check({7'h00, probe(1)}, 8'h01);
      smc_field_model_i.reset_pulse(10);
      smc_field_model_i.wait_ms(20);
      check({7'h00, probe(1)}, 8'h01);
      rearm();
      @(posedge clock_in);
      prot_a <= 1'b0;
      expect_within(1, RESP * MS);
      @(posedge clock_in);
      prot_a <= 1'b1;
      rearm();
      $display("test trip done");
   endtask : t_trip
   task automatic t_mute();
      @(posedge clock_in);
      enable <= 1'b1;
      smc_field_model_i.sense(4'h1);
      smc_field_model_i.wait_ms(20);
      smc_field_model_i.sense(4'h3);
      expect_within(2, 50 * MS);
      enable <= 1'b0;
      mut_a <= 1'b0;
      hold_on(100 * MS);
      @(posedge clock_in);
      prot_b <= 1'b0;
      expect_within(1, RESP * MS);
      @(posedge clock_in);
      mut_a <= 1'b1;
      prot_b <= 1'b1;
      smc_field_model_i.sense(4'h0);
      rearm();
      $display("test mute done");
   endtask : t_mute
   task automatic t_refuse();
      @(posedge clock_in);
      enable <= 1'b1;
      smc_field_model_i.sense(4'h1);
      smc_field_model_i.wait_ms(SIMUL + 50);
      smc_field_model_i.sense(4'h3);
      smc_field_model_i.wait_ms(50);
      check({7'h00, lamp}, 8'h00);
      smc_field_model_i.sense(4'h0);
      smc_field_model_i.wait_ms(20);
      enable <= 1'b0;
      smc_field_model_i.sense(4'h1);
      smc_field_model_i.wait_ms(20);
      smc_field_model_i.sense(4'h3);
      smc_field_model_i.wait_ms(50);
      check({7'h00, lamp}, 8'h00);
      smc_field_model_i.sense(4'h0);
      smc_field_model_i.wait_ms(20);
      enable <= 1'b1;
      smc_field_model_i.sense(4'h4);
      smc_field_model_i.wait_ms(20);
      smc_field_model_i.sense(4'hC);
      expect_within(2, 50 * MS);
      smc_field_model_i.sense(4'h0);
      smc_field_model_i.wait_ms(50);
      $display("test refuse done");
   endtask : t_refuse
   task automatic t_override();
      smc_field_model_i.sense(4'h1);
      mut_a <= 1'b0;
      expect_within(1, RESP * MS);
      smc_field_model_i.close_override(20);
      expect_within(0, 50 * MS);
      hold_on((OVR_MAX - 50) * MS);
      expect_within(1, 100 * MS);
      smc_field_model_i.open_override(20);
      smc_field_model_i.close_override(10);
      smc_field_model_i.wait_ms(50);
      check({7'h00, probe(1)}, 8'h01);
      smc_field_model_i.open_override(REARM + 20);
      smc_field_model_i.close_override(10);
      expect_within(0, 50 * MS);
      smc_field_model_i.open_override(0);
      expect_within(1, RESP * MS);
      mut_a <= 1'b1;
      smc_field_model_i.sense(4'h0);
      rearm();
      $display("test override done");
   endtask : t_override
   task automatic t_pulses();
      int i;
      int run;
      int last;
      int cnt;
      int bad;
      run = 0;
      last = -1;
      cnt = 0;
      bad = 0;
      for (i = 0; i < 300 * MS + 10; i++) begin
         @(posedge clock_in);
         #1;
         run = (outs[0] === 1'b1) ? 0 : run + 1;
         if (run == 1 && last >= 0 && i - last <= 100 * MS) bad++;
         if (run == 1) last = i;
         if (run == 1) cnt++;
         if (run > 1) bad++;
      end
      check({7'h00, cnt > 0}, 8'h01);
      check(bad[7:0], 8'h00);
      expect_within(0, 10);
      check({7'h00, aux}, 8'h01);
      $display("test pulses done");
   endtask : t_pulses
   task automatic t_cfg();
      @(posedge clock_in);
      cfg_b <= CFG ^ 8'h02;
      expect_within(1, 20 * MS);
      smc_field_model_i.wait_ms(5);
      check(disp, `SMC_ERR_CFG);
      @(posedge clock_in);
      cfg_b <= CFG;
      smc_field_model_i.reset_pulse(50);
      rearm();
      $display("test config done");
   endtask : t_cfg
   task automatic t_lamp();
      @(posedge clock_in);
      enable <= 1'b1;
      cfg_a <= CFG | 8'h04;
      cfg_b <= CFG | 8'h04;
      smc_field_model_i.sense(4'h1);
      smc_field_model_i.wait_ms(20);
      smc_field_model_i.sense(4'h3);
      expect_within(2, 50 * MS);
      lamp_ma <= 9'h005;
      smc_field_model_i.wait_ms(5);
      check(disp, `SMC_ERR_LAMP);
      lamp_ma <= 9'h064;
      smc_field_model_i.sense(4'h0);
      smc_field_model_i.wait_ms(20);
      smc_field_model_i.sense(4'h1);
      smc_field_model_i.wait_ms(20);
      smc_field_model_i.sense(4'h3);
      smc_field_model_i.wait_ms(50);
      check({7'h00, lamp}, 8'h00);
      smc_field_model_i.sense(4'h0);
      @(posedge clock_in);
      cfg_a <= CFG;
      cfg_b <= CFG;
      rst_in <= 1'b1;
      repeat (2) @(posedge clock_in);
      rst_in <= 1'b0;
      smc_field_model_i.wait_ms(5);
      check({6'h00, outs}, 8'h00);
      rearm();
      $display("test lamp done");
   endtask : t_lamp
   task automatic results();
      $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : results
   initial begin
      repeat (16) @(posedge clock_in);
      rst_in <= 1'b0;
      smc_field_model_i.wait_ms(20);
      check({6'h00, outs}, 8'h00);
      rearm();
      t_trip();
      t_mute();
      t_refuse();
      t_override();
      t_lamp();
      t_pulses();
      t_cfg();
      results();
   end
   initial begin
      repeat (100000) @(posedge clock_in);
      error_cnt++;
      results();
   end
endmodule : smc_core_test

// >>> tb/smc_field_model.sv
module smc_field_model #(
   parameter int MS = 20
) (
   input wire logic clock_in,
   input wire logic [1:0] safety_output_in,
   output logic [3:0] mute_sensor_out,
   output logic [1:0] override_out,
   output logic reset_input_out,
   output logic [1:0] feedback_out
);
   timeunit 1ns;
   timeprecision 1ps;
   // ****************************************
   // contacts and relays on the machine side
   // ****************************************
   logic [1:0] drive_reg = 2'h0;
   initial begin
      mute_sensor_out = 4'h0;
      override_out = 2'h0;
      reset_input_out = 1'b0;
      feedback_out = 2'h3;
   end
   // relays ignore one-cycle test pulses
   always @(posedge clock_in) begin
      drive_reg <= safety_output_in;
      if (drive_reg == safety_output_in) feedback_out <= ~drive_reg;
   end
   task automatic wait_ms(input int n);
      repeat (n * MS) @(posedge clock_in);
   endtask : wait_ms
   task automatic reset_pulse(input int ms);
      @(posedge clock_in);
      reset_input_out <= 1'b1;
      wait_ms(ms);
      reset_input_out <= 1'b0;
   endtask : reset_pulse
   task automatic sense(input logic [3:0] mask);
      @(posedge clock_in);
      mute_sensor_out <= mask;
   endtask : sense
   task automatic close_override(input int gap_ms);
      @(posedge clock_in);
      override_out <= 2'h1;
      wait_ms(gap_ms);
      override_out <= 2'h3;
   endtask : close_override
   task automatic open_override(input int hold_ms);
      @(posedge clock_in);
      override_out <= 2'h0;
      wait_ms(hold_ms);
   endtask : open_override
endmodule : smc_field_model
